// file: common/dcp_pkg.sv
package dcp_pkg;

	// Clock rate and timing figures.
	localparam int SYS_CLK_MHZ = 50;
	localparam int PLL_LOCK_TIME_US = 1000;
	localparam int PLL_LOCK_CYCLES = PLL_LOCK_TIME_US * SYS_CLK_MHZ;

	// Channel count and register word width.
	localparam int NUM_CH = 4;
	localparam int REG_W = 24;

	// Register addresses.
	localparam logic [7:0] ADDR_CHANNEL_SELECT = 8'h00;
	localparam logic [7:0] ADDR_GLOBAL_FUNCTION = 8'h01;
	localparam logic [7:0] ADDR_CHANNEL_FUNCTION = 8'h03;
	localparam logic [7:0] ADDR_CLOCK_STATUS = 8'h20;

	// Channel select register layout: enables sit in the upper nibble.
	localparam int CSR_EN_LSB = 4;
	localparam logic [3:0] CSR_EN_RESET = 4'hf;

	// Global function register layout.
	localparam int FR_VCO_HIGH_BIT = 23;
	localparam int FR_MULT_LSB = 18;
	localparam int FR_MULT_W = 5;
	localparam int FR_CLK_IN_PD_BIT = 7;
	localparam int FR_FULL_PD_SEL_BIT = 6;
	localparam logic [23:0] FR_RESET = 24'h000000;
	localparam logic [4:0] MULT_MIN = 5'h04;
	localparam logic [4:0] MULT_MAX = 5'h14;
	localparam logic [4:0] MULT_BYPASS = 5'h01;

	// Channel function register layout.
	localparam int CF_SCALE_LSB = 8;
	localparam int CF_DIG_PD_BIT = 7;
	localparam int CF_DAC_PD_BIT = 6;
	localparam logic [23:0] CF_RESET = 24'h000300;

	// Full-scale current codes.
	localparam logic [1:0] SCALE_FULL = 2'h3;
	localparam logic [1:0] SCALE_HALF = 2'h1;
	localparam logic [1:0] SCALE_QUARTER = 2'h2;

	// Clock status register bits.
	localparam int ST_LOCKING_BIT = 0;
	localparam int ST_PLL_EN_BIT = 1;
	localparam int ST_FULL_PD_BIT = 2;
	localparam int ST_FAST_PD_BIT = 3;

	// Per-channel analog and digital controls.
	typedef struct packed {
		logic [1:0] scale_code;
		logic [1:0] scale_shift;
		logic dig_pd;
		logic dac_pd;
		logic clk_pd;
	} dcp_chan_out_type;

	// Right shift of the reference current for a scaling code.
	function automatic logic [1:0] dcp_scale_shift(input logic [1:0] code);
		logic [1:0] sh;
		sh = 2'h3;
		if (code == SCALE_FULL) begin
			sh = 2'h0;
		end else if (code == SCALE_HALF) begin
			sh = 2'h1;
		end else if (code == SCALE_QUARTER) begin
			sh = 2'h2;
		end
		return sh;
	endfunction

endpackage

// file: hdl/dcp_channel.sv
`timescale 1ns/10ps
module dcp_channel import dcp_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_wr_en,
	input wire logic [REG_W-1:0] i_wr_data,
	input wire logic i_ext_sleep,
	input wire logic i_full_pd,
	input wire logic i_clk_in_pd,
	output logic [REG_W-1:0] o_cfg,
	output dcp_chan_out_type o_out
);

	typedef struct packed {
		logic [REG_W-1:0] cfg;
		dcp_chan_out_type out;
	} dcp_chan_state_type;

	dcp_chan_state_type st;
	dcp_chan_state_type next_st;

	// Outputs follow the stored word one cycle later, so a write and a pin
	// change both settle before the analog controls move.
	always_comb begin
		next_st = st;
		if (i_wr_en) begin
			next_st.cfg = i_wr_data; // [R15]
		end
		next_st.out.scale_code = st.cfg[CF_SCALE_LSB +: 2]; // [R07]
		next_st.out.scale_shift = dcp_scale_shift(st.cfg[CF_SCALE_LSB +: 2]);
		if (i_ext_sleep) begin
			// Software bits are don't care while the pin is high.
			next_st.out.dig_pd = 1'b1; // [R09] [R10]
			next_st.out.dac_pd = i_full_pd; // [R11]
			next_st.out.clk_pd = i_full_pd; // [R11]
		end else begin
			next_st.out.dig_pd = st.cfg[CF_DIG_PD_BIT]; // [R08] [R12] [R14]
			next_st.out.dac_pd = st.cfg[CF_DAC_PD_BIT]; // [R08] [R12] [R14]
			next_st.out.clk_pd = i_clk_in_pd; // [R08]
		end
	end

	// State register with synchronous reset.
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			st.cfg <= CF_RESET;
			st.out <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_cfg = st.cfg;
	assign o_out = st.out;

endmodule

// file: hdl/dcp_top.sv
`timescale 1ns/10ps
// Overview of operation
// R01: Multiplier field of 4 to 20 enables the multiplier with that factor.
// R02: Field below 4 or above 20 bypasses the multiplier, factor one.
// R03: System clock equals reference rate times the programmed factor.
// R04: Host waits about 1 ms for lock after enabling or changing.
// R05: Output 100 to 500 MHz; gain range bit resets low, host sets it.
// R06: Mode pin high enables crystal oscillator, low the input buffer.
// R07: Two-bit code scales each DAC: full, half, quarter, eighth.
// R08: Per-channel software bits power down clock input, DAC and logic; the clock-input bit here is the single global bit 7 (R17).
// R09: External sleep pin high makes software power-down bits don't care.
// R10: Pin high, select 0: only digital logic powered down, analog runs.
// R11: Pin high, select 1: everything powered down including multiplier.
// R12: Pin low: software power-down bits govern the power state.
// R13: Bypassed multiplier is shut down to save power.
// R14: Power-down value 1 means low power, 0 means powered up.
// R15: Scaling and power-down fields live in channel function register.
// R16: Channel enables act at once, steering shared-register writes.
// R17: Global clock-input power-down bit behaves like channel bits.
module dcp_top import dcp_pkg::*; #(
	parameter int LOCK_CYCLES = PLL_LOCK_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_wr_en,
	input wire logic [7:0] i_wr_addr,
	input wire logic [REG_W-1:0] i_wr_data,
	input wire logic i_rd_en,
	input wire logic [7:0] i_rd_addr,
	input wire logic i_clk_mode_sel,
	input wire logic i_external_sleep_pin,
	output logic [REG_W-1:0] o_rd_data,
	output logic o_pll_enable,
	output logic [FR_MULT_W-1:0] o_pll_factor,
	output logic o_pll_powerdown,
	output logic o_pll_locking,
	output logic o_vco_high_range,
	output logic o_xtal_osc_enable,
	output logic o_ref_buffer_enable,
	output logic o_dac_bias_powerdown,
	output logic o_fast_powerdown,
	output logic o_full_powerdown,
	output dcp_chan_out_type [NUM_CH-1:0] o_chan
);

	// The counter is wide enough to hold the whole settle time.
	localparam int LCW = $clog2(LOCK_CYCLES + 1);

	// A lock wait shorter than one cycle cannot be counted.
	if (LOCK_CYCLES < 1) begin : g_bad_lock
		$error("LOCK_CYCLES must be at least one");
	end

	// Lock timer is either idle or counting down the settle time.
	typedef enum logic [0:0] {
		LOCK_IDLE,
		LOCK_WAIT
	} dcp_lock_type;

	// All top-level registered state in one word; every output but o_chan is a flop of it, so
	// no analog control ever sees a combinational glitch.
	typedef struct packed {
		logic [NUM_CH-1:0] chan_en;
		logic [REG_W-1:0] fr;
		dcp_lock_type lock_st;
		logic [LCW-1:0] lock_cnt;
		logic [REG_W-1:0] rd_data;
		logic pll_en;
		logic [FR_MULT_W-1:0] pll_factor;
		logic pll_pd;
		logic vco_high;
		logic xtal_en;
		logic refbuf_en;
		logic bias_pd;
		logic fast_pd;
		logic full_pd;
	} dcp_state_type;

	dcp_state_type st;
	dcp_state_type next_st;
	// Stored channel words, the word a read returns, the multiplier field.
	logic [REG_W-1:0] chan_cfg [NUM_CH];
	logic [REG_W-1:0] sel_cfg;
	logic [FR_MULT_W-1:0] mult;
	logic mult_in_range;

	// Channel instances; each takes a shared-address write only while its
	// enable bit is set.
	for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
		dcp_channel u_chan (
			.i_sys_clk(i_sys_clk),
			.i_nrst(i_nrst),
			.i_wr_en(i_wr_en && (i_wr_addr == ADDR_CHANNEL_FUNCTION)
				&& st.chan_en[g]), // [R16]
			.i_wr_data(i_wr_data),
			.i_ext_sleep(i_external_sleep_pin),
			.i_full_pd(st.full_pd),
			.i_clk_in_pd(st.fr[FR_CLK_IN_PD_BIT]), // [R17]
			.o_cfg(chan_cfg[g]),
			.o_out(o_chan[g])
		);
	end

	// A read of the shared address returns the lowest enabled channel.
	always_comb begin
		sel_cfg = '0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (st.chan_en[i]) begin
				sel_cfg = chan_cfg[i];
			end
		end
	end

	// Out-of-range values are legal to write; they simply select bypass.
	assign mult = st.fr[FR_MULT_LSB +: FR_MULT_W];
	assign mult_in_range = (mult >= MULT_MIN) && (mult <= MULT_MAX); // [R01]

	// Register writes, read data, clock and power decode, lock timer.
	always_comb begin
		next_st = st;
		if (i_wr_en) begin
			if (i_wr_addr == ADDR_CHANNEL_SELECT) begin
				next_st.chan_en = i_wr_data[CSR_EN_LSB +: NUM_CH]; // [R16]
			end else if (i_wr_addr == ADDR_GLOBAL_FUNCTION) begin
				next_st.fr = i_wr_data;
			end
		end

		// Unmapped addresses read as zero.
		if (i_rd_en) begin
			next_st.rd_data = '0;
			if (i_rd_addr == ADDR_CHANNEL_SELECT) begin
				next_st.rd_data[CSR_EN_LSB +: NUM_CH] = st.chan_en;
			end else if (i_rd_addr == ADDR_GLOBAL_FUNCTION) begin
				next_st.rd_data = st.fr;
			end else if (i_rd_addr == ADDR_CHANNEL_FUNCTION) begin
				next_st.rd_data = sel_cfg;
			end else if (i_rd_addr == ADDR_CLOCK_STATUS) begin
				next_st.rd_data[ST_LOCKING_BIT] = (st.lock_st == LOCK_WAIT);
				next_st.rd_data[ST_PLL_EN_BIT] = st.pll_en;
				next_st.rd_data[ST_FULL_PD_BIT] = st.full_pd;
				next_st.rd_data[ST_FAST_PD_BIT] = st.fast_pd;
			end
		end

		// The pin decides first; the select bit only picks how deep.
		next_st.full_pd = i_external_sleep_pin
			&& st.fr[FR_FULL_PD_SEL_BIT]; // [R11] [R14]
		next_st.fast_pd = i_external_sleep_pin
			&& !st.fr[FR_FULL_PD_SEL_BIT]; // [R10]
		next_st.bias_pd = next_st.full_pd; // [R10] [R11]
		next_st.vco_high = st.fr[FR_VCO_HIGH_BIT]; // [R05]

		// Bypass passes the reference straight through at factor one.
		next_st.pll_en = mult_in_range && !next_st.full_pd; // [R01] [R11]
		next_st.pll_factor = mult_in_range ? mult : MULT_BYPASS; // [R02] [R03]
		next_st.pll_pd = !next_st.pll_en; // [R13]

		// The oscillator dies in full power-down; the buffer also follows
		// the global clock-input bit while the pin is low.
		next_st.xtal_en = i_clk_mode_sel && !next_st.full_pd; // [R06]
		next_st.refbuf_en = !i_clk_mode_sel && !next_st.full_pd
			&& (i_external_sleep_pin
			|| !st.fr[FR_CLK_IN_PD_BIT]); // [R06] [R09] [R17]

		// Lock wait restarts on every enable or factor change, so a host
		// that polls the status never trusts a half-settled loop.
		case (st.lock_st)
			LOCK_IDLE: begin
				if (next_st.pll_en && (!st.pll_en
					|| next_st.pll_factor != st.pll_factor)) begin
					next_st.lock_st = LOCK_WAIT; // [R04]
					next_st.lock_cnt = LCW'(LOCK_CYCLES - 1);
				end
			end
			LOCK_WAIT: begin
				if (!next_st.pll_en) begin
					next_st.lock_st = LOCK_IDLE;
					next_st.lock_cnt = '0;
				end else if (next_st.pll_factor != st.pll_factor) begin
					next_st.lock_cnt = LCW'(LOCK_CYCLES - 1); // [R04]
				end else if (st.lock_cnt == '0) begin
					next_st.lock_st = LOCK_IDLE;
				end else begin
					next_st.lock_cnt = st.lock_cnt - 1'b1;
				end
			end
			// Unreachable with two states; a corrupted code falls back idle.
			default: begin
				next_st.lock_st = LOCK_IDLE;
			end
		endcase
	end

	// State register with synchronous reset; the gain range resets low.
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			st <= '0;
			st.chan_en <= CSR_EN_RESET;
			st.fr <= FR_RESET; // [R05]
			st.lock_st <= LOCK_IDLE;
			// Bypass at factor one, multiplier held down until written.
			st.pll_factor <= MULT_BYPASS;
			st.pll_pd <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs are plain copies of the state flops.
	assign o_rd_data = st.rd_data;
	assign o_pll_enable = st.pll_en;
	assign o_pll_factor = st.pll_factor;
	assign o_pll_powerdown = st.pll_pd;
	assign o_pll_locking = (st.lock_st == LOCK_WAIT);
	assign o_vco_high_range = st.vco_high;
	assign o_xtal_osc_enable = st.xtal_en;
	assign o_ref_buffer_enable = st.refbuf_en;
	assign o_dac_bias_powerdown = st.bias_pd;
	assign o_fast_powerdown = st.fast_pd;
	assign o_full_powerdown = st.full_pd;

endmodule

// file: tb/dcp_top_monitor.sv
`timescale 1ns/10ps
// Port-level watch on the multiplier and power-down controls.
module dcp_top_monitor import dcp_pkg::*; #(
	parameter int LOCK_CYCLES = 20
) (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_wr_en,
	input wire logic [7:0] i_wr_addr,
	input wire logic [REG_W-1:0] i_wr_data,
	input wire logic i_external_sleep_pin,
	input wire logic o_pll_enable,
	input wire logic [FR_MULT_W-1:0] o_pll_factor,
	input wire logic o_pll_powerdown,
	input wire logic o_pll_locking,
	input wire logic o_xtal_osc_enable,
	input wire logic o_dac_bias_powerdown,
	input wire logic o_fast_powerdown,
	input wire logic o_full_powerdown,
	input wire dcp_chan_out_type [NUM_CH-1:0] o_chan
);
	logic fr_wr;
	logic ok_f;
	// Global writes, and whether the written factor lies in range.
	assign fr_wr = i_wr_en && i_wr_addr == ADDR_GLOBAL_FUNCTION;
	assign ok_f = i_wr_data[22:18] >= MULT_MIN &&
		i_wr_data[22:18] <= MULT_MAX;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	AST_PD_INV:
	assert property (o_pll_powerdown == !o_pll_enable)
		else $error("pll power-down wrong");
	AST_FACTOR:
	assert property (fr_wr && ok_f && !i_wr_data[6] |-> ##2
		o_pll_factor == $past(i_wr_data[22:18], 2)) else $error("factor");
	AST_BYPASS:
	assert property (fr_wr && !ok_f |-> ##2
		!o_pll_enable && o_pll_factor == MULT_BYPASS) else $error("bypass");
	AST_PIN:
	assert property ($past(i_nrst) |-> (o_fast_powerdown ||
		o_full_powerdown) == $past(i_external_sleep_pin)) else $error("pin");
	AST_EXCL:
	assert property (!(o_fast_powerdown && o_full_powerdown))
		else $error("both modes");
	AST_FULL:
	assert property (o_full_powerdown |-> !o_pll_enable &&
		o_dac_bias_powerdown && !o_xtal_osc_enable) else $error("full");
	AST_LOCK:
	assert property ($rose(o_pll_enable) |=> o_pll_locking)
		else $error("no lock wait");
	AST_LOCK_END:
	assert property ($rose(o_pll_locking) |-> ##[1:100] !o_pll_locking)
		else $error("lock wait stuck");
	AST_DIG:
	assert property ($past(i_nrst) && $past(i_external_sleep_pin) |->
		o_chan[0].dig_pd && o_chan[3].dig_pd) else $error("dig pd");
endmodule

// file: tb/dcp_ref_src.sv
`timescale 1ns/10ps
// Board clock source: a strap picks crystal or driven reference.
module dcp_ref_src (
	input wire logic i_fit_xtal,
	input wire logic i_osc_en,
	input wire logic i_buf_en,
	output logic o_clk_mode_sel,
	output logic o_ref_clk
);
	// The strap is a static level on the mode pin.
	assign o_clk_mode_sel = i_fit_xtal;
	// The reference swings only while its receiving pad is awake.
	initial begin
		o_ref_clk = 1'b0;
		forever #25 o_ref_clk = (i_osc_en | i_buf_en) & !o_ref_clk;
	end
endmodule

// file: tb/dds_clock_and_power_control_tb.sv
`timescale 1ns/10ps
module dds_clock_and_power_control_tb import dcp_pkg::*; ;
	logic i_sys_clk, i_nrst, i_wr_en, i_rd_en, i_external_sleep_pin, xt;
	logic [7:0] i_wr_addr, i_rd_addr;
	logic [23:0] i_wr_data, fr, o_rd_data;
	logic [23:0] cf [4];
	logic [23:0] eq [$];
	logic [31:0] seed, r;
	int sq [$];
	int fv [7] = '{0, 3, 4, 10, 20, 21, 31};
	int num_errors, num_checks;
	wire i_clk_mode_sel, ref_clk;
	logic [4:0] o_pll_factor;
	logic o_pll_enable, o_pll_powerdown, o_pll_locking, o_vco_high_range;
	logic o_xtal_osc_enable, o_ref_buffer_enable, o_dac_bias_powerdown;
	logic o_fast_powerdown, o_full_powerdown;
	dcp_chan_out_type [3:0] o_chan;
	dcp_top #(.LOCK_CYCLES(20)) u_dcp_top (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_wr_en(i_wr_en),
		.i_wr_addr(i_wr_addr),
		.i_wr_data(i_wr_data),
		.i_rd_en(i_rd_en),
		.i_rd_addr(i_rd_addr),
		.i_clk_mode_sel(i_clk_mode_sel),
		.i_external_sleep_pin(i_external_sleep_pin),
		.o_rd_data(o_rd_data),
		.o_pll_enable(o_pll_enable),
		.o_pll_factor(o_pll_factor),
		.o_pll_powerdown(o_pll_powerdown),
		.o_pll_locking(o_pll_locking),
		.o_vco_high_range(o_vco_high_range),
		.o_xtal_osc_enable(o_xtal_osc_enable),
		.o_ref_buffer_enable(o_ref_buffer_enable),
		.o_dac_bias_powerdown(o_dac_bias_powerdown),
		.o_fast_powerdown(o_fast_powerdown),
		.o_full_powerdown(o_full_powerdown),
		.o_chan(o_chan)
	);
	dcp_ref_src u_dcp_ref_src (.i_fit_xtal(xt), .i_osc_en(o_xtal_osc_enable),
		.i_buf_en(o_ref_buffer_enable), .o_clk_mode_sel(i_clk_mode_sel),
		.o_ref_clk(ref_clk));
	// Reads before this edge's updates land, so stimulus cannot race it.
	always @(posedge i_sys_clk) begin
		logic [23:0] g;
		while (eq.size() > 0) begin
			if (sq[0] == 0) begin
				g = o_rd_data;
			end else if (sq[0] == 1) begin
				g = {11'h0, o_pll_enable, o_pll_factor, o_pll_powerdown,
					o_fast_powerdown, o_full_powerdown, o_xtal_osc_enable,
					o_ref_buffer_enable, o_dac_bias_powerdown, o_vco_high_range};
			end else begin
				// Notes 2 to 5 stand for channels 0 to 3.
				g = {17'h0, o_chan[(sq[0] - 2) & 3]};
			end
			num_checks++;
			if (g !== eq[0]) begin
				num_errors++;
				$display("[FAIL] %0t exp %h got %h", $time, eq[0], g);
			end
			void'(eq.pop_front());
			void'(sq.pop_front());
		end
	end
	// Expected top controls; f, ir and fl are field, in range and full
	// power-down. The factor follows the field even in full power-down.
	function automatic logic [23:0] tx(logic p);
		logic [4:0] f;
		logic fl;
		logic ir;
		logic en;
		f = fr[22:18];
		fl = p & fr[6];
		ir = f >= MULT_MIN && f <= MULT_MAX;
		en = ir && !fl;
		return {11'h0, en, ir ? f : 5'h01, !en, p & !fl, fl, xt & !fl,
			!xt & !fl & (p | !fr[7]), fl, fr[23]};
	endfunction
	// Expected channel controls; the shift is the inverted code swapped.
	function automatic logic [23:0] chx(int c, logic p);
		logic [1:0] k;
		k = cf[c][9:8];
		if (p) begin
			return {17'h0, k, ~k[0], ~k[1], 1'b1, fr[6], fr[6]};
		end
		return {17'h0, k, ~k[0], ~k[1], cf[c][7:6], fr[7]};
	endfunction
	task automatic note(int s, logic [23:0] v);
		eq.push_back(v);
		sq.push_back(s);
	endtask
	task automatic notes(logic p);
		note(1, tx(p));
		for (int k = 0; k < 4; k++) begin
			note(2 + k, chx(k, p));
		end
	endtask
	// An idle cycle closes each access, so back-to-back calls never drive
	// a strobe twice in one time step.
	task automatic wr(logic [7:0] a, logic [23:0] d);
		i_wr_addr = a;
		i_wr_data = d;
		i_wr_en = 1'b1;
		@(negedge i_sys_clk);
		i_wr_en = 1'b0;
		@(negedge i_sys_clk);
	endtask
	task automatic rd(logic [7:0] a, logic [23:0] v);
		i_rd_addr = a;
		i_rd_en = 1'b1;
		@(negedge i_sys_clk);
		i_rd_en = 1'b0;
		note(0, v);
		@(negedge i_sys_clk);
	endtask
	task automatic step();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		r = seed;
	endtask
	task automatic close_out();
		// A note never compared counts against the run.
		if (eq.size() != 0) begin
			num_errors++;
			$display("[FAIL] %0t exp %h got %h", $time, 0, eq.size());
		end
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		i_sys_clk = 1'b0;
		forever #10 i_sys_clk = !i_sys_clk;
	end
	// Main sequence; all stimulus moves on the falling edge.
	initial begin
		{i_nrst, i_wr_en, i_rd_en, i_external_sleep_pin, xt} = 5'h00;
		{i_wr_addr, i_rd_addr, i_wr_data, fr} = 64'h0;
		cf = '{4{24'h000300}};
		seed = 32'hbd5f0e5c;
		num_errors = 0;
		num_checks = 0;
		repeat (4) @(negedge i_sys_clk);
		i_nrst = 1'b1;
		repeat (3) @(negedge i_sys_clk);
		notes(1'b0);
		rd(ADDR_CHANNEL_FUNCTION, 24'h000300);
		rd(8'h55, 24'h0);
		foreach (fv[i]) begin
			step();
			xt = r[0];
			fr = {r[1], fv[i][4:0], 18'h0};
			wr(ADDR_GLOBAL_FUNCTION, fr);
			repeat (3) @(negedge i_sys_clk);
			note(1, tx(1'b0));
			rd(ADDR_GLOBAL_FUNCTION, fr);
		end
		fr = 24'h280000;
		wr(ADDR_GLOBAL_FUNCTION, fr);
		repeat (4) @(negedge i_sys_clk);
		rd(ADDR_CLOCK_STATUS, 24'h3);
		repeat (30) @(negedge i_sys_clk);
		rd(ADDR_CLOCK_STATUS, 24'h2);
		for (int c = 0; c < 4; c++) begin
			step();
			fr[7] = r[2];
			wr(ADDR_GLOBAL_FUNCTION, fr);
			wr(ADDR_CHANNEL_SELECT, 24'h10 << c);
			cf[c] = {14'h0, c[1:0], r[4:3], 6'h0};
			wr(ADDR_CHANNEL_FUNCTION, cf[c]);
			repeat (3) @(negedge i_sys_clk);
			rd(ADDR_CHANNEL_FUNCTION, cf[c]);
			notes(1'b0);
		end
		for (int p = 0; p < 2; p++) begin
			fr = {fr[23], 5'h02, 10'h0, fr[7], p[0], 6'h0};
			wr(ADDR_GLOBAL_FUNCTION, fr);
			i_external_sleep_pin = 1'b1;
			repeat (3) @(negedge i_sys_clk);
			notes(1'b1);
			rd(ADDR_CLOCK_STATUS, {20'h0, !p[0], p[0], 2'h0});
			i_external_sleep_pin = 1'b0;
		end
		wr(8'h02, 24'hffffff);
		rd(ADDR_GLOBAL_FUNCTION, fr);
		@(negedge i_sys_clk);
		close_out();
	end
endmodule

bind dcp_top dcp_top_monitor #(.LOCK_CYCLES(LOCK_CYCLES)) u_mon (
	.i_sys_clk(i_sys_clk),
	.i_nrst(i_nrst),
	.i_wr_en(i_wr_en),
	.i_wr_addr(i_wr_addr),
	.i_wr_data(i_wr_data),
	.i_external_sleep_pin(i_external_sleep_pin),
	.o_pll_enable(o_pll_enable),
	.o_pll_factor(o_pll_factor),
	.o_pll_powerdown(o_pll_powerdown),
	.o_pll_locking(o_pll_locking),
	.o_xtal_osc_enable(o_xtal_osc_enable),
	.o_dac_bias_powerdown(o_dac_bias_powerdown),
	.o_fast_powerdown(o_fast_powerdown),
	.o_full_powerdown(o_full_powerdown),
	.o_chan(o_chan)
);
